// ===== hdl/mfd_pkg.sv
// constants and types for the microword datapath field decoder
package mfd_pkg;

	// ****************************************
	// microword field positions
	// ****************************************
	localparam int MFD_MICROWORD_W = 48;
	localparam int MFD_SECTOR_LSB = 0;
	localparam int MFD_SECTOR_W = 4;
	localparam int MFD_BADDR_LSB = 4;
	localparam int MFD_AADDR_LSB = 7;
	localparam int MFD_PADDR_W = 3;
	localparam int MFD_DST_LSB = 27;
	localparam int MFD_DST_W = 4;
	localparam int MFD_ASEL_BIT = 32;
	localparam int MFD_BSEL_LSB = 33;
	localparam int MFD_EXPCTL_LSB = 36;
	localparam int MFD_FRACCTL_LSB = 42;
	localparam int MFD_ALUCTL_W = 6;

	// ****************************************
	// codes
	// ****************************************
	localparam logic [3:0] MFD_DST_SHIFT_LEFT_Q = 4'hd;
	localparam logic [3:0] MFD_STACK_BASE = 4'h8;
	localparam logic [1:0] MFD_BSEL_IRDST = 2'h1;
	localparam logic [1:0] MFD_BSEL_IRSRC = 2'h2;

	// ****************************************
	// register map and reset values
	// ****************************************
	localparam logic [11:0] MFD_CTRL_ADDR = 12'h000;
	localparam logic [11:0] MFD_STATUS_ADDR = 12'h004;
	localparam logic [11:0] MFD_COUNT_ADDR = 12'h008;
	localparam logic [11:0] MFD_PORTS_ADDR = 12'h00c;
	localparam logic [11:0] MFD_ALU_ADDR = 12'h010;
	localparam logic MFD_CTRL_RUN_RST = 1'b1;
	localparam logic [3:0] MFD_CTRL_MASK_RST = 4'hf;
	localparam int MFD_CTRL_RUN_BIT = 0;
	localparam int MFD_CTRL_MASK_LSB = 4;
	localparam int MFD_CTRL_CLRCNT_BIT = 8;

	// one row of the destination decode
	typedef struct packed {
		logic [2:0] fracDst;
		logic [2:0] expDst;
		logic shiftRightN;
		logic rotateLeftN;
		logic shiftLeftN;
		logic insertZeroN;
		logic oneZeroSelN;
		logic rotateRightN;
	} mfd_dst_s;

endpackage : mfd_pkg

// ===== hdl/mfd_microword_datapath_field_decoder.sv
// microword field decoder driving the bit-slice datapath controls
// Overview of operation
// - four sector bits, one per sector
// - each sector clock gated independently
// - zero sector field gives no strobes
// - latched sector bit forms active-low strobe
// - strobe clocks stack, port latches, quotient
// - bits 27-30 decoded into destination selects
// - code 13 shifts left, quotient takes carry
// - code 13 drives select 6 both
// - shift gates float when all inactive
// - left-shift low inserts zero at stack
// - precision flag picks one quotient shift
// - a address bits 7-9, b 4-6
// - select bits choose instruction or microword
// - codes 5-7 reach stack locations 15-17
// - codes 0-4 reach working registers 10-14
// - fraction bits 42-47, exponent 36-41
// - low digit source, high digit function
// - alu selects registered before slices
// - fraction and exponent controls independent
// - latches load only with float enable
//
// The register addresses and the APB slave port were chosen for this implementation.
module mfd_microword_datapath_field_decoder #(
	parameter int MICROWORD_W = mfd_pkg::MFD_MICROWORD_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [MICROWORD_W-1:0] microWord,
	input wire logic floatInstructionEnable,
	input wire logic doublePrecisionFlag,
	input wire logic [3:0] irSrcField,
	input wire logic [3:0] irDstField,
	output logic [3:0] sectorStrobeN,
	output logic [2:0] fractionDestinationSelect,
	output logic [2:0] exponentDestinationSelect,
	output logic leftShiftDoubleCarryN,
	output logic leftShiftSingleCarryN,
	output logic shiftRightN,
	output logic rotateLeftN,
	output logic shiftLeftN,
	output logic insertZeroN,
	output logic oneZeroSelN,
	output logic rotateRightN,
	output logic shiftGateOe,
	output logic [3:0] aPortAddr,
	output logic [3:0] bPortAddr,
	output logic [2:0] fractionSrcSelect,
	output logic [2:0] fractionFuncSelect,
	output logic [2:0] exponentSrcSelect,
	output logic [2:0] exponentFuncSelect
);
	import mfd_pkg::*;

	// ****************************************
	// elaboration checks
	// ****************************************
	if (MICROWORD_W < MFD_MICROWORD_W) begin : g_width_check
		$error("microword too narrow for the decoded fields");
	end
	if (MFD_FRACCTL_LSB + MFD_ALUCTL_W > MICROWORD_W) begin : g_field_check
		$error("fraction control field beyond the microword");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [3:0] sectorN;
		mfd_dst_s dst;
		logic lsDoubleN;
		logic lsSingleN;
		logic gateOe;
		logic [3:0] aPort;
		logic [3:0] bPort;
		logic [2:0] fracSrc;
		logic [2:0] fracFunc;
		logic [2:0] expSrc;
		logic [2:0] expFunc;
		logic run;
		logic [3:0] sectorMask;
		logic [15:0] cycleCount;
		logic [3:0] lastSector;
		logic [3:0] lastDst;
		logic lastLoaded;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} mfd_state_s;

	mfd_state_s state_reg;
	mfd_state_s state_next;

	// ****************************************
	// destination decode table
	// ****************************************
	function automatic mfd_dst_s mfd_dst_decode(input logic [3:0] code);
		mfd_dst_s r;
		r = '{fracDst: 3'h1, expDst: 3'h1, default: 1'b1};
		case (code)
			4'h0: begin
				r.fracDst = 3'h1;
				r.expDst = 3'h1;
			end
			4'h1: begin
				r.fracDst = 3'h2;
				r.expDst = 3'h2;
			end
			4'h2: begin
				r.fracDst = 3'h3;
				r.expDst = 3'h3;
			end
			4'h3: begin
				r.fracDst = 3'h0;
				r.expDst = 3'h0;
			end
			4'h4: begin
				r.fracDst = 3'h7;
				r.expDst = 3'h7;
				r.rotateLeftN = 1'b0;
			end
			4'h5: begin
				r.fracDst = 3'h5;
				r.expDst = 3'h5;
				r.rotateRightN = 1'b0;
			end
			4'h6: begin
				r.fracDst = 3'h7;
				r.expDst = 3'h7;
				r.shiftLeftN = 1'b0;
			end
			4'h7: begin
				r.fracDst = 3'h5;
				r.expDst = 3'h5;
				r.shiftRightN = 1'b0;
				r.oneZeroSelN = 1'b0;
			end
			4'h8: begin
				r.fracDst = 3'h5;
				r.expDst = 3'h5;
				r.shiftRightN = 1'b0;
			end
			4'h9: begin
				r.fracDst = 3'h7;
				r.expDst = 3'h3;
				r.insertZeroN = 1'b0;
			end
			4'ha: begin
				r.fracDst = 3'h5;
				r.expDst = 3'h3;
				r.shiftRightN = 1'b0;
			end
			4'hc: begin
				r.fracDst = 3'h4;
				r.expDst = 3'h4;
				r.shiftRightN = 1'b0;
				r.oneZeroSelN = 1'b0;
			end
			4'hd: begin
				r.fracDst = 3'h6;
				r.expDst = 3'h6;
				r.shiftLeftN = 1'b0;
			end
			default: begin
				r.fracDst = 3'h1;
				r.expDst = 3'h1;
			end
		endcase
		return r;
	endfunction : mfd_dst_decode

	// ****************************************
	// port address expansion
	// ****************************************
	function automatic logic [3:0] mfd_stack_addr(input logic [2:0] code);
		// codes 0-4 map to 10-14 octal, 5-7 to the status words at 15-17 octal
		return MFD_STACK_BASE | {1'b0, code};
	endfunction : mfd_stack_addr

	// ****************************************
	// next state
	// ****************************************
	logic [MFD_SECTOR_W-1:0] sectorField;
	logic [MFD_DST_W-1:0] dstField;
	logic [MFD_PADDR_W-1:0] aCode;
	logic [MFD_PADDR_W-1:0] bCode;
	logic aSel;
	logic [1:0] bSel;
	logic [MFD_ALUCTL_W-1:0] fracCtl;
	logic [MFD_ALUCTL_W-1:0] expCtl;
	logic loadFields;
	logic apbAccess;
	logic apbDone;
	mfd_dst_s dstRow;

	always_comb begin
		sectorField = microWord[MFD_SECTOR_LSB +: MFD_SECTOR_W];
		dstField = microWord[MFD_DST_LSB +: MFD_DST_W];
		aCode = microWord[MFD_AADDR_LSB +: MFD_PADDR_W];
		bCode = microWord[MFD_BADDR_LSB +: MFD_PADDR_W];
		aSel = microWord[MFD_ASEL_BIT];
		bSel = microWord[MFD_BSEL_LSB +: 2];
		fracCtl = microWord[MFD_FRACCTL_LSB +: MFD_ALUCTL_W];
		expCtl = microWord[MFD_EXPCTL_LSB +: MFD_ALUCTL_W];
		loadFields = floatInstructionEnable & state_reg.run;
		apbAccess = psel & penable;
		apbDone = apbAccess & state_reg.ready;
		dstRow = mfd_dst_decode(dstField);

		state_next = state_reg;

		// sector strobes: one low cycle per set bit not cleared in sectorMask, high when not loading
		if (loadFields) begin
			for (int i = 0; i < MFD_SECTOR_W; i++) begin
				// each bit gated on its own; zero field leaves all high
				state_next.sectorN[i] = ~(sectorField[i] & state_reg.sectorMask[i]);
			end
		end else begin
			state_next.sectorN = '1;
		end

		// destination and shift controls
		if (loadFields) begin
			state_next.dst = dstRow;
			state_next.lsDoubleN = 1'b1;
			state_next.lsSingleN = 1'b1;
			if (dstField == MFD_DST_SHIFT_LEFT_Q) begin
				// carry-out goes to exactly one quotient shift path
				state_next.lsDoubleN = ~doublePrecisionFlag;
				state_next.lsSingleN = doublePrecisionFlag;
			end
			state_next.gateOe = ~(dstRow.rotateRightN & dstRow.shiftRightN
				& dstRow.rotateLeftN & dstRow.insertZeroN);
		end

		// a and b port addresses
		if (loadFields) begin
			state_next.aPort = aSel ? irSrcField : mfd_stack_addr(aCode);
			case (bSel)
				MFD_BSEL_IRDST: state_next.bPort = irDstField;
				MFD_BSEL_IRSRC: state_next.bPort = irSrcField;
				default: state_next.bPort = mfd_stack_addr(bCode);
			endcase
		end

		// alu source and function, separate for fraction and exponent
		if (loadFields) begin
			state_next.fracSrc = fracCtl[2:0];
			state_next.fracFunc = fracCtl[5:3];
			state_next.expSrc = expCtl[2:0];
			state_next.expFunc = expCtl[5:3];
		end

		// observation of the last loaded microcycle
		state_next.lastLoaded = loadFields;
		if (loadFields) begin
			state_next.lastSector = sectorField;
			state_next.lastDst = dstField;
			state_next.cycleCount = state_reg.cycleCount + 16'h0001;
		end

		// apb slave: one wait cycle, answer registered
		state_next.ready = apbAccess & ~state_reg.ready;
		if (apbAccess & ~state_reg.ready) begin
			state_next.rdata = 32'h0000_0000;
			state_next.slverr = 1'b0;
			case (paddr)
				MFD_CTRL_ADDR: begin
					state_next.rdata[MFD_CTRL_RUN_BIT] = state_reg.run;
					state_next.rdata[MFD_CTRL_MASK_LSB +: 4] = state_reg.sectorMask;
				end
				MFD_STATUS_ADDR: begin
					state_next.rdata[3:0] = ~state_reg.sectorN;
					state_next.rdata[7:4] = state_reg.lastSector;
					state_next.rdata[11:8] = state_reg.lastDst;
					state_next.rdata[12] = doublePrecisionFlag;
					state_next.rdata[13] = floatInstructionEnable;
					state_next.rdata[14] = state_reg.lastLoaded;
					state_next.rdata[15] = state_reg.gateOe;
				end
				MFD_COUNT_ADDR: begin
					state_next.rdata = {16'h0000, state_reg.cycleCount};
				end
				MFD_PORTS_ADDR: begin
					state_next.rdata[3:0] = state_reg.bPort;
					state_next.rdata[7:4] = state_reg.aPort;
					state_next.rdata[15:8] = {state_reg.lsDoubleN, state_reg.lsSingleN,
						state_reg.dst.shiftRightN, state_reg.dst.rotateLeftN,
						state_reg.dst.shiftLeftN, state_reg.dst.insertZeroN,
						state_reg.dst.oneZeroSelN, state_reg.dst.rotateRightN};
					state_next.rdata[18:16] = state_reg.dst.expDst;
					state_next.rdata[21:19] = state_reg.dst.fracDst;
				end
				MFD_ALU_ADDR: begin
					state_next.rdata[2:0] = state_reg.expSrc;
					state_next.rdata[5:3] = state_reg.expFunc;
					state_next.rdata[8:6] = state_reg.fracSrc;
					state_next.rdata[11:9] = state_reg.fracFunc;
				end
				default: begin
					state_next.slverr = 1'b1;
				end
			endcase
		end else if (~apbAccess) begin
			state_next.slverr = 1'b0;
		end

		// register writes take effect at the completing edge
		if (apbDone & pwrite & (paddr == MFD_CTRL_ADDR)) begin
			state_next.run = pwdata[MFD_CTRL_RUN_BIT];
			state_next.sectorMask = pwdata[MFD_CTRL_MASK_LSB +: 4];
			if (pwdata[MFD_CTRL_CLRCNT_BIT]) begin
				// a load in the same cycle still counts
				state_next.cycleCount = loadFields ? 16'h0001 : 16'h0000;
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.sectorN <= '1;
			state_reg.dst <= '{fracDst: 3'h1, expDst: 3'h1, default: 1'b1};
			state_reg.lsDoubleN <= 1'b1;
			state_reg.lsSingleN <= 1'b1;
			state_reg.aPort <= MFD_STACK_BASE;
			state_reg.bPort <= MFD_STACK_BASE;
			state_reg.run <= MFD_CTRL_RUN_RST;
			state_reg.sectorMask <= MFD_CTRL_MASK_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slverr;
	assign sectorStrobeN = state_reg.sectorN;
	assign fractionDestinationSelect = state_reg.dst.fracDst;
	assign exponentDestinationSelect = state_reg.dst.expDst;
	assign leftShiftDoubleCarryN = state_reg.lsDoubleN;
	assign leftShiftSingleCarryN = state_reg.lsSingleN;
	assign shiftRightN = state_reg.dst.shiftRightN;
	assign rotateLeftN = state_reg.dst.rotateLeftN;
	assign shiftLeftN = state_reg.dst.shiftLeftN;
	assign insertZeroN = state_reg.dst.insertZeroN;
	assign oneZeroSelN = state_reg.dst.oneZeroSelN;
	assign rotateRightN = state_reg.dst.rotateRightN;
	assign shiftGateOe = state_reg.gateOe;
	assign aPortAddr = state_reg.aPort;
	assign bPortAddr = state_reg.bPort;
	assign fractionSrcSelect = state_reg.fracSrc;
	assign fractionFuncSelect = state_reg.fracFunc;
	assign exponentSrcSelect = state_reg.expSrc;
	assign exponentFuncSelect = state_reg.expFunc;

endmodule : mfd_microword_datapath_field_decoder

// ===== tb/mfd_control_store.sv
// control store model: microword source and float enable latch
module mfd_control_store (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [10:0] mpcAddr,
	input wire logic [47:0] wordIn,
	input wire logic fullWidth,
	output logic [47:0] microWord,
	output logic floatInstructionEnable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic floatLatch_reg;
	// start address sets the latch, address zero clears it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			floatLatch_reg <= 1'b0;
		else if (mpcAddr == 11'h028)
			floatLatch_reg <= 1'b1;
		else if (mpcAddr == 11'h000)
			floatLatch_reg <= 1'b0;
	end
	assign floatInstructionEnable = mpcAddr == 11'h028 || (floatLatch_reg && mpcAddr != 11'h000);
	// full width copies the fraction code into the exponent field
	assign microWord = fullWidth ? {wordIn[47:42], wordIn[47:42], wordIn[35:0]} : wordIn;
endmodule : mfd_control_store

// ===== tb/mfd_monitor.sv
// assertion checker for the microword field decoder
module mfd_monitor #(
	parameter int MICROWORD_W = mfd_pkg::MFD_MICROWORD_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [MICROWORD_W-1:0] microWord,
	input wire logic floatInstructionEnable,
	input wire logic doublePrecisionFlag,
	input wire logic [3:0] sectorStrobeN,
	input wire logic [2:0] fractionDestinationSelect,
	input wire logic [2:0] exponentDestinationSelect,
	input wire logic leftShiftDoubleCarryN,
	input wire logic leftShiftSingleCarryN,
	input wire logic shiftRightN,
	input wire logic rotateLeftN,
	input wire logic shiftLeftN,
	input wire logic insertZeroN,
	input wire logic rotateRightN,
	input wire logic shiftGateOe,
	input wire logic [3:0] bPortAddr,
	input wire logic [2:0] fractionFuncSelect
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// properties
	// ****
	logic loadSeen;
	assign loadSeen = sectorStrobeN != 4'hf;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_idle; !floatInstructionEnable |=> sectorStrobeN == 4'hf; endproperty
	a_idle: assert property (p_idle) else $error("strobe while idle");
	property p_sect; (~sectorStrobeN & ~$past(microWord[3:0])) == 4'h0; endproperty
	a_sect: assert property (p_sect) else $error("strobe on clear bit");
	property p_gate; shiftGateOe == !(rotateRightN && shiftRightN && rotateLeftN && insertZeroN);
	endproperty
	a_gate: assert property (p_gate) else $error("shift gate enable");
	property p_slq; loadSeen && $past(microWord[30:27]) == 4'hd |->
		fractionDestinationSelect == 3'h6 && exponentDestinationSelect == 3'h6 && !shiftLeftN;
	endproperty
	a_slq: assert property (p_slq) else $error("shift left quotient decode");
	property p_prec; loadSeen && $past(microWord[30:27]) == 4'hd |->
		leftShiftDoubleCarryN == !$past(doublePrecisionFlag) &&
		leftShiftSingleCarryN == $past(doublePrecisionFlag);
	endproperty
	a_prec: assert property (p_prec) else $error("carry line choice");
	property p_bport; loadSeen && $past(microWord[34:33]) == 2'h0 |->
		bPortAddr == {1'b1, $past(microWord[6:4])};
	endproperty
	a_bport: assert property (p_bport) else $error("b port address");
	property p_alu; loadSeen |-> fractionFuncSelect == $past(microWord[47:45]); endproperty
	a_alu: assert property (p_alu) else $error("fraction function");
	property p_hold; !floatInstructionEnable |=> $stable(bPortAddr) && $stable(fractionFuncSelect);
	endproperty
	a_hold: assert property (p_hold) else $error("fields changed while idle");
	c_all: cover property (loadSeen && sectorStrobeN == 4'h0);
	c_dbl: cover property (!leftShiftDoubleCarryN);
	c_sgl: cover property (!leftShiftSingleCarryN);
endmodule : mfd_monitor

bind mfd_microword_datapath_field_decoder mfd_monitor #(.MICROWORD_W(MICROWORD_W))
	u_mfd_monitor (
	.clk(clk), .rstn(rstn), .microWord(microWord),
	.floatInstructionEnable(floatInstructionEnable),
	.doublePrecisionFlag(doublePrecisionFlag),
	.sectorStrobeN(sectorStrobeN),
	.fractionDestinationSelect(fractionDestinationSelect),
	.exponentDestinationSelect(exponentDestinationSelect),
	.leftShiftDoubleCarryN(leftShiftDoubleCarryN),
	.leftShiftSingleCarryN(leftShiftSingleCarryN),
	.shiftRightN(shiftRightN), .rotateLeftN(rotateLeftN), .shiftLeftN(shiftLeftN),
	.insertZeroN(insertZeroN), .rotateRightN(rotateRightN), .shiftGateOe(shiftGateOe),
	.bPortAddr(bPortAddr), .fractionFuncSelect(fractionFuncSelect));

// ===== tb/microword_datapath_field_decoder_tb.sv
// self-checking testbench for the microword field decoder
module microword_datapath_field_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mfd_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic floatInstructionEnable, doublePrecisionFlag = 0, fullWidth = 0, run = 1;
	logic [47:0] microWord, wordIn = 48'h0000_0000_0000;
	logic [10:0] mpcAddr = 11'h000;
	logic [3:0] irSrcField = 4'h0, irDstField = 4'h0, sectorStrobeN, aPortAddr, bPortAddr;
	logic [2:0] fractionDestinationSelect, exponentDestinationSelect, fractionSrcSelect;
	logic [2:0] fractionFuncSelect, exponentSrcSelect, exponentFuncSelect;
	logic leftShiftDoubleCarryN, leftShiftSingleCarryN, shiftRightN, rotateLeftN, shiftLeftN;
	logic insertZeroN, oneZeroSelN, rotateRightN, shiftGateOe, ldPend = 0, wasLd = 0;
	logic [3:0] mask = 4'hf;
	logic [38:0] last = {4'hf, 14'h09ff, 1'b0, 8'h88, 12'h000};
	logic [38:0] expQ[$];
	logic [47:0] w, lastW = 48'h0000_0000_0000;
	int errTotal = 0, checkCount = 0, loads = 0;
	integer seed = 32'h3b3f_09e8;
	logic [13:0] dstTab [16] = '{14'h09ff, 14'h12ff, 14'h1bff, 14'h00ff, 14'h3fef, 14'h2dfe,
		14'h3ff7, 14'h2ddd, 14'h2ddf, 14'h3bfb, 14'h2bdf, 14'h09ff, 14'h24dd, 14'h36b7, 14'h09ff,
		14'h09ff};
	wire logic [38:0] seen = {sectorStrobeN, fractionDestinationSelect, exponentDestinationSelect,
		leftShiftDoubleCarryN, leftShiftSingleCarryN, shiftRightN, rotateLeftN, shiftLeftN,
		insertZeroN, oneZeroSelN, rotateRightN, shiftGateOe, aPortAddr, bPortAddr,
		fractionSrcSelect, fractionFuncSelect, exponentSrcSelect, exponentFuncSelect};

	always #10 clk = ~clk;

	mfd_control_store u_mfd_control_store (.clk(clk), .rstn(rstn), .mpcAddr(mpcAddr),
		.wordIn(wordIn), .fullWidth(fullWidth), .microWord(microWord),
		.floatInstructionEnable(floatInstructionEnable));
	mfd_microword_datapath_field_decoder u_mfd_microword_datapath_field_decoder (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.microWord(microWord), .floatInstructionEnable(floatInstructionEnable),
		.doublePrecisionFlag(doublePrecisionFlag), .irSrcField(irSrcField),
		.irDstField(irDstField), .sectorStrobeN(sectorStrobeN),
		.fractionDestinationSelect(fractionDestinationSelect),
		.exponentDestinationSelect(exponentDestinationSelect),
		.leftShiftDoubleCarryN(leftShiftDoubleCarryN),
		.leftShiftSingleCarryN(leftShiftSingleCarryN),
		.shiftRightN(shiftRightN), .rotateLeftN(rotateLeftN), .shiftLeftN(shiftLeftN),
		.insertZeroN(insertZeroN), .oneZeroSelN(oneZeroSelN), .rotateRightN(rotateRightN),
		.shiftGateOe(shiftGateOe), .aPortAddr(aPortAddr), .bPortAddr(bPortAddr),
		.fractionSrcSelect(fractionSrcSelect), .fractionFuncSelect(fractionFuncSelect),
		.exponentSrcSelect(exponentSrcSelect), .exponentFuncSelect(exponentFuncSelect));

	// ****
	// tasks
	// ****
	task automatic check(input string what, input logic [47:0] got, input logic [47:0] exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic finalReport();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finalReport

	function automatic logic [47:0] rnd48();
		return {16'($random(seed)), 32'($random(seed))};
	endfunction : rnd48

	function automatic logic [38:0] expOf(input logic [47:0] v, input logic f,
		input logic [3:0] s, input logic [3:0] d);
		logic [13:0] t;
		logic [3:0] b;
		t = dstTab[v[30:27]];
		if (v[30:27] == 4'hd) t[7:6] = {!f, f};
		b = v[34:33] == 2'h1 ? d : v[34:33] == 2'h2 ? s : {1'b1, v[6:4]};
		return {~(v[3:0] & mask), t, !(t[5] & t[4] & t[2] & t[0]), v[32] ? s : {1'b1, v[9:7]}, b,
			v[44:42], v[47:45], v[38:36], v[41:39]};
	endfunction : expOf

	task automatic step(input logic [47:0] v, input logic en, input logic f, input logic fw);
		logic [3:0] s, d;
		logic [47:0] m;
		s = 4'($random(seed));
		d = 4'($random(seed));
		m = v;
		if (fw) m[41:36] = v[47:42];
		wordIn <= v;
		fullWidth <= fw;
		mpcAddr <= en ? 11'h028 : 11'h000;
		doublePrecisionFlag <= f;
		irSrcField <= s;
		irDstField <= d;
		ldPend <= en & run;
		if (en & run) begin
			expQ.push_back(expOf(m, f, s, d));
			lastW = m;
			loads++;
		end
		@(posedge clk);
	endtask : step

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [32:0] ex);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		if (!wr) check("apb read", 48'({pslverr, prdata}), 48'(ex));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// ****
	// result watcher and main sequence
	// ****
	always @(posedge clk) wasLd <= ldPend;
	always @(negedge clk) begin
		if (rstn) begin
			if (wasLd) last = expQ.pop_front();
			else last[38:35] = 4'hf;
			check("decode outputs", 48'(seen), 48'(last));
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 32; i++) begin
			w = rnd48();
			step({w[47:35], i[4:2], w[31], i[3:0], w[26:10], i[2:0], ~i[2:0], i[3:0]}, 1, i[4], 0);
		end
		$display("test sweep done");
		repeat (60) begin
			w = rnd48();
			step(rnd48(), w[0] | w[1], w[2], w[3]);
		end
		$display("test random done");
		step(rnd48(), 1'b0, 1'b0, 1'b0);
		apb(0, MFD_CTRL_ADDR, 32'h0000_0000, {1'b0, 32'h0000_00f1});
		apb(0, MFD_STATUS_ADDR, 32'h0000_0000, {17'h0_0000, last[20], 3'h0, lastW[30:27],
			lastW[3:0], 4'h0});
		apb(0, MFD_PORTS_ADDR, 32'h0000_0000, {11'h000, last[34:21], last[19:12]});
		apb(0, MFD_ALU_ADDR, 32'h0000_0000, {21'h00_0000, last[8:6], last[11:9], last[2:0],
			last[5:3]});
		apb(1, MFD_COUNT_ADDR, 32'h0000_5555, 33'h0);
		apb(0, MFD_COUNT_ADDR, 32'h0000_0000, {1'b0, 32'(loads)});
		apb(1, MFD_CTRL_ADDR, 32'h0000_0051, 33'h0);
		mask = 4'h5;
		repeat (8) step(rnd48(), 1'b1, 1'b0, 1'b0);
		step(rnd48(), 1'b0, 1'b0, 1'b0);
		apb(0, MFD_COUNT_ADDR, 32'h0000_0000, {1'b0, 32'(loads)});
		apb(1, MFD_CTRL_ADDR, 32'h0000_0150, 33'h0);
		loads = 0;
		run = 0;
		apb(0, MFD_CTRL_ADDR, 32'h0000_0000, {1'b0, 32'h0000_0050});
		repeat (4) step(rnd48(), 1'b1, 1'b1, 1'b0);
		step(rnd48(), 1'b0, 1'b0, 1'b0);
		apb(0, 12'h0ff, 32'h0000_0000, {1'b1, 32'h0000_0000});
		apb(0, MFD_COUNT_ADDR, 32'h0000_0000, {1'b0, 32'(loads)});
		$display("test registers done");
		repeat (3) @(posedge clk);
		check("queue drained", 48'(expQ.size()), 48'h0000_0000_0000);
		finalReport();
	end

	// about 180 cycles expected; cut off well beyond that
	initial begin
		repeat (3000) @(posedge clk);
		errTotal++;
		finalReport();
	end
endmodule : microword_datapath_field_decoder_tb
